// File: design/split_completion_generator.sv
module split_completion_generator (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic clkEn,
	input wire logic reqValid,
	input wire split_cpl_pkg::reqInfo_t reqInfo,
	output logic reqReady,
	input wire logic [7:0] cplBus,
	input wire logic [4:0] cplDev,
	input wire logic [2:0] cplFunc,
	input wire logic shortenFirst,
	input wire logic wideEn,
	input wire logic [31:0] msgWord,
	input wire logic msgErr,
	input wire logic rdValid,
	input wire logic [31:0] rdData,
	output logic rdReady,
	output logic txnReq,
	output split_cpl_pkg::cplHdr_t hdr,
	output logic req64,
	input wire logic hdrAck,
	output logic dataValid,
	output logic [31:0] dataWord,
	output logic [3:0] laneValid,
	output logic [3:0] cbeData,
	input wire logic dataReady,
	input wire logic linkDisc
);

	function automatic logic [12:0] beatBytes(input logic [1:0] off,
		input logic [12:0] rem);
		logic [12:0] room;
		room = 13'h0004 - {11'h000, off};
		beatBytes = (rem < room) ? rem : room;
	endfunction

	function automatic logic [3:0] laneMask(input logic [1:0] off,
		input logic [12:0] n);
		logic [3:0] m;
		m = 4'h0;
		case (n[2:0])
			3'h1: m = 4'h1;
			3'h2: m = 4'h3;
			3'h3: m = 4'h7;
			default: m = 4'hf;
		endcase
		laneMask = m << off;
	endfunction

	split_cpl_pkg::state_t state_q;
	split_cpl_pkg::reqInfo_t reqQ;
	logic firstQ;
	logic heldQ;
	logic [6:0] nextAddr_q;
	logic [12:0] seqRem_q;
	logic [12:0] txnRem_q;
	logic [31:0] bufMem [2];
	logic bufWr_q;
	logic bufRd_q;
	logic [1:0] bufCnt_q;
	logic [1:0] bufCnt_d;

	logic isMsg;
	logic accept;
	logic [12:0] curBytes;
	logic txnLast;
	logic txnStop;
	logic canLoad;
	logic push;
	logic pop;
	logic shortOk;
	logic [12:0] firstRun;
	logic [12:0] txnLen;

	assign isMsg = reqQ.kind == split_cpl_pkg::KIND_WRITE;
	assign accept = dataValid && dataReady;
	assign curBytes = beatBytes(nextAddr_q[1:0], txnRem_q);
	assign txnLast = accept && (txnRem_q == curBytes);
	// A disconnect from the target, or the last beat, closes the transaction
	assign txnStop = state_q == split_cpl_pkg::S_DATA &&
		(txnLast || linkDisc);
	// One beat in flight keeps the counters exact across a disconnect,
	// at the cost of half the data rate.
	assign canLoad = state_q == split_cpl_pkg::S_DATA && !dataValid &&
		!linkDisc && txnRem_q != 13'h0000 &&
		(heldQ || isMsg || bufCnt_q != 2'h0);
	assign push = rdValid && rdReady;
	assign pop = canLoad && !heldQ && !isMsg;

	// Shorten only off-boundary first completions of a burst read
	assign firstRun = split_cpl_pkg::BOUNDARY_BYTES - {6'h00, nextAddr_q};
	assign shortOk = firstQ && shortenFirst &&
		reqQ.kind == split_cpl_pkg::KIND_BURST_READ &&
		nextAddr_q != split_cpl_pkg::LOW_ADDR_ZERO &&
		firstRun < seqRem_q;
	assign txnLen = shortOk ? firstRun : seqRem_q;

	always_comb begin
		bufCnt_d = bufCnt_q;
		if (push && !pop) begin
			bufCnt_d = bufCnt_q + 2'h1;
		end else if (pop && !push) begin
			bufCnt_d = bufCnt_q - 2'h1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			bufWr_q <= 1'b0;
			bufRd_q <= 1'b0;
			bufCnt_q <= 2'h0;
			rdReady <= 1'b0;
		end else if (clkEn) begin
			if (push) begin
				bufWr_q <= !bufWr_q;
			end
			if (pop) begin
				bufRd_q <= !bufRd_q;
			end
			bufCnt_q <= bufCnt_d;
			rdReady <= bufCnt_d != split_cpl_pkg::BUF_DEPTH;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (clkEn && push) begin
			bufMem[bufWr_q] <= rdData;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			state_q <= split_cpl_pkg::S_IDLE;
			reqReady <= 1'b0;
		end else if (clkEn) begin
			case (state_q)
				split_cpl_pkg::S_IDLE: begin
					reqReady <= 1'b1;
					if (reqValid && reqReady) begin
						state_q <= split_cpl_pkg::S_PREP;
						reqReady <= 1'b0;
					end
				end
				split_cpl_pkg::S_PREP: begin
					state_q <= split_cpl_pkg::S_HDR;
				end
				split_cpl_pkg::S_HDR: begin
					if (hdrAck) begin
						state_q <= split_cpl_pkg::S_DATA;
					end
				end
				split_cpl_pkg::S_DATA: begin
					if (txnStop) begin
						if (seqRem_q == (accept ? curBytes : 13'h0000)) begin
							state_q <= split_cpl_pkg::S_IDLE;
						end else begin
							state_q <= split_cpl_pkg::S_PREP;
						end
					end
				end
				default: begin
					state_q <= split_cpl_pkg::S_IDLE;
				end
			endcase
		end
	end

	// Sequence record survives any number of disconnections
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			reqQ <= '0;
			firstQ <= 1'b0;
			nextAddr_q <= 7'h00;
			seqRem_q <= 13'h0000;
			txnRem_q <= 13'h0000;
		end else if (clkEn) begin
			if (state_q == split_cpl_pkg::S_IDLE && reqValid && reqReady) begin
				reqQ <= reqInfo;
				firstQ <= 1'b1;
				if (reqInfo.kind == split_cpl_pkg::KIND_BURST_READ) begin
					nextAddr_q <= reqInfo.lowAddr;
					seqRem_q <= (reqInfo.byteCount == 12'h000) ?
						split_cpl_pkg::FULL_COUNT :
						{1'b0, reqInfo.byteCount};
				end else begin
					nextAddr_q <= split_cpl_pkg::LOW_ADDR_ZERO;
					seqRem_q <= split_cpl_pkg::DWORD_BYTES;
				end
			end else if (state_q == split_cpl_pkg::S_PREP) begin
				txnRem_q <= txnLen;
				firstQ <= 1'b0;
			end else if (state_q == split_cpl_pkg::S_DATA && accept) begin
				nextAddr_q <= nextAddr_q + curBytes[6:0];
				seqRem_q <= seqRem_q - curBytes;
				txnRem_q <= txnRem_q - curBytes;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			txnReq <= 1'b0;
			hdr <= '0;
			req64 <= 1'b0;
		end else if (clkEn) begin
			if (state_q == split_cpl_pkg::S_PREP) begin
				txnReq <= 1'b1;
				req64 <= wideEn;
				hdr.addr.relaxed <= reqQ.relaxed;
				hdr.addr.tag <= reqQ.tag;
				hdr.addr.reqBus <= reqQ.reqBus;
				hdr.addr.reqDev <= reqQ.reqDev;
				hdr.addr.reqFunc <= reqQ.reqFunc;
				hdr.addr.lowAddr <= nextAddr_q;
				hdr.attr.byteCountModified <= shortOk;
				hdr.attr.sce <= isMsg && msgErr;
				hdr.attr.scm <= isMsg;
				hdr.attr.cplBus <= cplBus;
				hdr.attr.cplDev <= cplDev;
				hdr.attr.cplFunc <= cplFunc;
				hdr.attr.byteCount <= txnLen[11:0];
			end else if (state_q == split_cpl_pkg::S_HDR && hdrAck) begin
				txnReq <= 1'b0;
			end
		end
	end

	// Data phases; a word refused at a disconnect is replayed on resume
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			dataValid <= 1'b0;
			dataWord <= 32'h0000_0000;
			laneValid <= 4'h0;
			cbeData <= split_cpl_pkg::CBE_RESERVED;
			heldQ <= 1'b0;
		end else if (clkEn) begin
			cbeData <= split_cpl_pkg::CBE_RESERVED;
			if (state_q == split_cpl_pkg::S_DATA && linkDisc) begin
				dataValid <= 1'b0;
				// A word kept from an earlier cut must stay kept
				heldQ <= heldQ || (dataValid && !dataReady);
			end else if (accept) begin
				dataValid <= 1'b0;
			end else if (canLoad) begin
				dataValid <= 1'b1;
				heldQ <= 1'b0;
				if (!heldQ) begin
					if (isMsg) begin
						dataWord <= msgWord;
						laneValid <= 4'hf;
					end else begin
						dataWord <= bufMem[bufRd_q];
					end
					if (reqQ.kind == split_cpl_pkg::KIND_DWORD_READ) begin
						laneValid <= reqQ.byteEn;
					end else if (!isMsg) begin
						laneValid <= laneMask(nextAddr_q[1:0], curBytes);
					end
				end
			end
		end
	end

	property p_cbe_high;
		@(posedge sys_clk) disable iff (sys_rst)
		dataValid |-> cbeData == split_cpl_pkg::CBE_RESERVED;
	endproperty
	a_cbe_high: assert property (p_cbe_high)
		else $error("byte enables not high in data phase");

	property p_req_id;
		@(posedge sys_clk) disable iff (sys_rst)
		txnReq |-> hdr.addr.reqBus == reqQ.reqBus &&
			hdr.addr.reqDev == reqQ.reqDev &&
			hdr.addr.reqFunc == reqQ.reqFunc;
	endproperty
	a_req_id: assert property (p_req_id)
		else $error("requester identity not in completion address");

	property p_dword_hdr;
		@(posedge sys_clk) disable iff (sys_rst)
		txnReq && reqQ.kind == split_cpl_pkg::KIND_DWORD_READ |->
			hdr.addr.lowAddr == 7'h00 && hdr.attr.byteCount == 12'h004;
	endproperty
	a_dword_hdr: assert property (p_dword_hdr)
		else $error("DWORD completion header wrong");

	property p_msg_hdr;
		@(posedge sys_clk) disable iff (sys_rst)
		txnReq && isMsg |-> hdr.attr.scm && !hdr.attr.byteCountModified &&
			hdr.attr.byteCount == 12'h004 && hdr.addr.lowAddr == 7'h00;
	endproperty
	a_msg_hdr: assert property (p_msg_hdr)
		else $error("message completion header wrong");

	property p_count_modified;
		@(posedge sys_clk) disable iff (sys_rst)
		$rose(txnReq) |-> hdr.attr.byteCountModified ==
			({1'b0, hdr.attr.byteCount} < seqRem_q[12:0] &&
			hdr.attr.byteCount != 12'h000);
	endproperty
	a_count_modified: assert property (p_count_modified)
		else $error("byte count modified flag mismatch");

	property p_short_to_boundary;
		@(posedge sys_clk) disable iff (sys_rst)
		txnReq && hdr.attr.byteCountModified |->
			{6'h00, hdr.addr.lowAddr} + {1'b0, hdr.attr.byteCount} ==
			split_cpl_pkg::BOUNDARY_BYTES && hdr.addr.lowAddr != 7'h00;
	endproperty
	a_short_to_boundary: assert property (p_short_to_boundary)
		else $error("shortened completion does not end at first boundary");

	property p_retry_busy;
		@(posedge sys_clk) disable iff (sys_rst)
		state_q != split_cpl_pkg::S_IDLE |-> !reqReady;
	endproperty
	a_retry_busy: assert property (p_retry_busy)
		else $error("second split request accepted while busy");

	sequence s_disc_open;
		state_q == split_cpl_pkg::S_DATA && linkDisc && !accept && clkEn;
	endsequence

	sequence s_prep_resume;
		state_q == split_cpl_pkg::S_PREP && clkEn && !firstQ;
	endsequence

	sequence s_resume_hdr;
		txnReq && hdr.addr.lowAddr == $past(nextAddr_q) &&
			hdr.attr.byteCount == $past(seqRem_q[11:0]) &&
			!hdr.attr.byteCountModified;
	endsequence

	property p_resume;
		@(posedge sys_clk) disable iff (sys_rst)
		s_disc_open |=> state_q == split_cpl_pkg::S_PREP;
	endproperty
	a_resume: assert property (p_resume)
		else $error("disconnect did not lead to a new header");

	// Any later header of a sequence carries the full remainder
	property p_resume_hdr;
		@(posedge sys_clk) disable iff (sys_rst)
		s_prep_resume |=> s_resume_hdr;
	endproperty
	a_resume_hdr: assert property (p_resume_hdr)
		else $error("resumed header not set to remaining portion");

	property p_dword_lanes;
		@(posedge sys_clk) disable iff (sys_rst)
		dataValid && reqQ.kind == split_cpl_pkg::KIND_DWORD_READ |->
			laneValid == reqQ.byteEn;
	endproperty
	a_dword_lanes: assert property (p_dword_lanes)
		else $error("DWORD read lanes differ from request enables");

	property p_addr_order;
		@(posedge sys_clk) disable iff (sys_rst)
		clkEn && state_q == split_cpl_pkg::S_DATA && accept &&
			!txnLast ##1
			state_q == split_cpl_pkg::S_DATA |->
			nextAddr_q == $past(nextAddr_q) + $past(curBytes[6:0]);
	endproperty
	a_addr_order: assert property (p_addr_order)
		else $error("completion address did not advance in order");

endmodule

// File: design/split_cpl_pkg.sv
package split_cpl_pkg;

	localparam logic [12:0] BOUNDARY_BYTES = 13'h0080;
	localparam logic [12:0] DWORD_BYTES = 13'h0004;
	localparam logic [12:0] FULL_COUNT = 13'h1000;
	localparam logic [3:0] CBE_RESERVED = 4'hf;
	localparam logic [6:0] LOW_ADDR_ZERO = 7'h00;
	localparam logic [1:0] BUF_DEPTH = 2'h2;

	typedef enum logic [1:0] {
		KIND_BURST_READ = 2'h0,
		KIND_DWORD_READ = 2'h1,
		KIND_WRITE = 2'h2
	} reqKind_t;

	// Captured from the address and attribute phases of the split request
	typedef struct packed {
		logic [7:0] reqBus;
		logic [4:0] reqDev;
		logic [2:0] reqFunc;
		logic [4:0] tag;
		logic relaxed;
		reqKind_t kind;
		logic [6:0] lowAddr;
		logic [11:0] byteCount;
		logic [3:0] byteEn;
	} reqInfo_t;

	typedef struct packed {
		logic relaxed;
		logic [4:0] tag;
		logic [7:0] reqBus;
		logic [4:0] reqDev;
		logic [2:0] reqFunc;
		logic [6:0] lowAddr;
	} cplAddr_t;

	typedef struct packed {
		logic byteCountModified;
		logic sce;
		logic scm;
		logic [7:0] cplBus;
		logic [4:0] cplDev;
		logic [2:0] cplFunc;
		logic [11:0] byteCount;
	} cplAttr_t;

	typedef struct packed {
		cplAddr_t addr;
		cplAttr_t attr;
	} cplHdr_t;

	typedef enum logic [3:0] {
		S_IDLE = 4'h1,
		S_PREP = 4'h2,
		S_HDR = 4'h4,
		S_DATA = 4'h8
	} state_t;

endpackage

// File: dv/cpl_target_model.sv
module cpl_target_model (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic clkEn,
	input wire logic txnReq,
	input wire logic [6:0] lowAddr,
	input wire logic dataValid,
	input wire logic slow,
	input wire logic [3:0] discBeat,
	output logic hdrAck,
	output logic dataReady,
	output logic linkDisc
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [4:0] dwPos = 5'h00;
	logic moved = 1'b0;
	logic [2:0] cnt = 3'h0;
	logic atEdge;
	initial begin
		hdrAck = 1'b0;
		dataReady = 1'b0;
		linkDisc = 1'b0;
	end
	// Next beat would open a new 128-byte block
	assign atEdge = discBeat != 4'h0 && moved && dwPos == 5'h00;
	always @(posedge sys_clk) begin
		cnt <= cnt + 3'h1;
		if (sys_rst) begin
			moved <= 1'b0;
		end else if (clkEn && txnReq && hdrAck) begin
			dwPos <= lowAddr[6:2];
			moved <= 1'b0;
		end else if (clkEn && dataValid && dataReady) begin
			dwPos <= dwPos + 5'h01;
			moved <= 1'b1;
		end
	end
	// Slow mode stalls on a fixed pattern so runs stay repeatable
	always @(negedge sys_clk) begin
		hdrAck <= txnReq && !hdrAck && (!slow || cnt[1:0] == 2'h3);
		// Cut only on a boundary, refusing the word that would cross it
		dataReady <= !sys_rst && (!slow || cnt[0]) &&
			!(dataValid && atEdge);
		linkDisc <= dataValid && atEdge;
	end
endmodule

// File: dv/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] CPL_BUS = 8'h21;
	localparam logic [4:0] CPL_DEV = 5'h03;
	localparam logic [2:0] CPL_FUNC = 3'h5;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic reqValid = 1'b0, shortenFirst = 1'b0, wideEn = 1'b0;
	logic msgErr = 1'b0, rdValid = 1'b0, slow = 1'b0, first = 1'b0;
	logic took = 1'b0, clkEn = 1'b1;
	logic [31:0] msgWord = 32'h0, rdData = 32'h0, seed = 32'h1;
	logic [3:0] discBeat = 4'h0;
	logic [12:0] addr = 13'h0, rem = 13'h0, feedLeft = 13'h0;
	split_cpl_pkg::reqInfo_t reqInfo = '0;
	split_cpl_pkg::cplHdr_t hdr;
	logic reqReady, rdReady, txnReq, req64, hdrAck, dataValid;
	logic dataReady, linkDisc;
	logic [31:0] dataWord;
	logic [3:0] laneValid, cbeData;
	logic [31:0] fifo[$];
	int nErrors = 0;
	int checks = 0;

	always #12.5 sys_clk = ~sys_clk;

	split_completion_generator uut (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.clkEn(clkEn), .reqValid(reqValid), .reqInfo(reqInfo),
		.reqReady(reqReady), .cplBus(CPL_BUS), .cplDev(CPL_DEV),
		.cplFunc(CPL_FUNC), .shortenFirst(shortenFirst), .wideEn(wideEn),
		.msgWord(msgWord), .msgErr(msgErr), .rdValid(rdValid),
		.rdData(rdData), .rdReady(rdReady), .txnReq(txnReq), .hdr(hdr),
		.req64(req64), .hdrAck(hdrAck), .dataValid(dataValid),
		.dataWord(dataWord), .laneValid(laneValid), .cbeData(cbeData),
		.dataReady(dataReady), .linkDisc(linkDisc));

	cpl_target_model far (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.clkEn(clkEn), .txnReq(txnReq), .lowAddr(hdr.addr.lowAddr),
		.dataValid(dataValid), .slow(slow),
		.discBeat(discBeat), .hdrAck(hdrAck), .dataReady(dataReady),
		.linkDisc(linkDisc));

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		checks++;
		if (seen !== exp) begin
			nErrors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	function automatic split_cpl_pkg::cplHdr_t expHdr(input logic sh,
		input logic [12:0] cnt);
		split_cpl_pkg::cplHdr_t h;
		logic burst;
		burst = reqInfo.kind == split_cpl_pkg::KIND_BURST_READ;
		h.addr.relaxed = reqInfo.relaxed;
		h.addr.tag = reqInfo.tag;
		h.addr.reqBus = reqInfo.reqBus;
		h.addr.reqDev = reqInfo.reqDev;
		h.addr.reqFunc = reqInfo.reqFunc;
		h.addr.lowAddr = burst ? addr[6:0] : split_cpl_pkg::LOW_ADDR_ZERO;
		h.attr.byteCountModified = sh;
		h.attr.scm = reqInfo.kind == split_cpl_pkg::KIND_WRITE;
		h.attr.sce = h.attr.scm && msgErr;
		h.attr.cplBus = CPL_BUS;
		h.attr.cplDev = CPL_DEV;
		h.attr.cplFunc = CPL_FUNC;
		h.attr.byteCount = cnt[11:0];
		return h;
	endfunction

	// Tracks next address and bytes left, independent of the design
	always @(posedge sys_clk) begin : mon
		logic [12:0] s, b;
		logic [7:0] m;
		logic [3:0] l;
		logic [31:0] mask, e;
		logic sh, burst;
		burst = reqInfo.kind == split_cpl_pkg::KIND_BURST_READ;
		if (!sys_rst && clkEn) begin
			if (txnReq)
				check(64'(reqReady), 64'(1'b0));
			if (txnReq && hdrAck) begin
				s = split_cpl_pkg::BOUNDARY_BYTES - {6'h0, addr[6:0]};
				sh = first && shortenFirst && burst &&
					addr[6:0] != 7'h0 && s < rem;
				e = 32'(sh ? s : (burst ? rem : split_cpl_pkg::DWORD_BYTES));
				check(64'(hdr), 64'(expHdr(sh, e[12:0])));
				check(64'(hdr.attr.byteCountModified), 64'(sh));
				check(64'(hdr.addr.lowAddr), 64'(addr[6:0]));
				check(64'(req64), 64'(wideEn));
				first = 1'b0;
			end
			if (dataValid && dataReady) begin
				b = 13'h4 - {11'h0, addr[1:0]};
				if (b > rem)
					b = rem;
				m = ((8'h1 << b[2:0]) - 8'h1) << addr[1:0];
				l = reqInfo.kind == split_cpl_pkg::KIND_DWORD_READ ?
					reqInfo.byteEn : m[3:0];
				mask = {{8{l[3]}}, {8{l[2]}}, {8{l[1]}}, {8{l[0]}}};
				check(64'(cbeData), 64'(split_cpl_pkg::CBE_RESERVED));
				if (reqInfo.kind == split_cpl_pkg::KIND_WRITE) begin
					check(64'(dataWord), 64'(msgWord));
					check(64'(laneValid), 64'(4'hf));
				end else begin
					e = fifo.size() > 0 ? fifo.pop_front() : ~dataWord;
					check(64'(laneValid), 64'(l));
					check(64'(dataWord & mask), 64'(e & mask));
				end
				addr = addr + b;
				rem = rem - b;
			end
			if (rdValid && rdReady) begin
				fifo.push_back(rdData);
				feedLeft = feedLeft - 13'h1;
				took = 1'b1;
			end
		end
	end

	// Word held until taken; new word offered only after acceptance
	always @(negedge sys_clk) begin : feed
		logic [31:0] r, c;
		// Clock enable dips now and then; held high through reset
		c = rnd();
		clkEn <= sys_rst || c[2:0] != 3'h0;
		if (took || !rdValid) begin
			r = rnd();
			rdData <= r;
			rdValid <= feedLeft != 13'h0 && r[3];
		end
		took = 1'b0;
	end

	task automatic run_seq(input split_cpl_pkg::reqKind_t k,
		input logic [6:0] lo, input logic [12:0] cnt, input logic sf,
		input logic [3:0] db);
		logic [31:0] r;
		int n;
		@(negedge sys_clk);
		r = rnd();
		reqInfo = {r[7:0], r[12:8], r[15:13], r[20:16], r[21], k, lo,
			cnt[11:0], r[25:22]};
		addr = k == split_cpl_pkg::KIND_BURST_READ ? {6'h0, lo} : 13'h0;
		rem = k == split_cpl_pkg::KIND_BURST_READ ? cnt : 13'h4;
		feedLeft = ({11'h0, addr[1:0]} + rem + 13'h3) >> 2;
		if (k == split_cpl_pkg::KIND_WRITE)
			feedLeft = 13'h0;
		first = 1'b1;
		shortenFirst = sf;
		wideEn = r[26];
		slow = r[27];
		msgErr = r[28];
		discBeat = db;
		msgWord = rnd();
		while (!reqReady)
			@(negedge sys_clk);
		reqValid = 1'b1;
		@(posedge sys_clk);
		while (!clkEn)
			@(posedge sys_clk);
		@(negedge sys_clk);
		reqValid = 1'b0;
		repeat (3) @(negedge sys_clk);
		n = 0;
		while (!reqReady && n < 20000) begin
			@(negedge sys_clk);
			n++;
		end
		check(64'(rem), 64'(0));
		check(64'(n < 20000), 64'(1));
		check(64'(fifo.size()), 64'(0));
	endtask

	task tally_and_finish;
		if (nErrors == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial begin
		repeat (60000) @(posedge sys_clk);
		nErrors++;
		tally_and_finish();
	end

	initial begin : main
		logic [31:0] r;
		repeat (5) @(posedge sys_clk);
		@(negedge sys_clk);
		sys_rst = 1'b0;
		check(64'({txnReq, dataValid, cbeData}), 64'({2'h0, 4'hf}));
		run_seq(split_cpl_pkg::KIND_DWORD_READ, 7'h35, 13'h40, 1'b1, 4'h0);
		run_seq(split_cpl_pkg::KIND_WRITE, 7'h11, 13'h100, 1'b1, 4'h0);
		run_seq(split_cpl_pkg::KIND_BURST_READ, 7'h00, 13'h100, 1'b1, 4'h0);
		run_seq(split_cpl_pkg::KIND_BURST_READ, 7'h7d, 13'h1000, 1'b1, 4'h3);
		run_seq(split_cpl_pkg::KIND_BURST_READ, 7'h42, 13'h0be, 1'b0, 4'h2);
		for (int i = 0; i < 12; i++) begin
			r = rnd();
			run_seq(r[1:0] == 2'h3 ? split_cpl_pkg::KIND_BURST_READ :
				split_cpl_pkg::reqKind_t'(r[1:0]), r[8:2],
				{4'h0, r[17:9]} + 13'h1, r[18], {2'h0, r[21:20]});
		end
		tally_and_finish();
	end
endmodule
